// file: rtl/palette_host_bus_port.sv
// Host controller that drives the palette port strobes, selects and data
`timescale 1ns/100ps
module palette_host_bus_port
  import palette_host_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_write,
  input  wire logic [2:0] cmd_select,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic       wide_color,
  output logic            rsp_valid,
  output logic [7:0]      rsp_rdata,
  output logic [1:0]      color_phase_count,
  output logic [7:0]      entry_pointer,
  output logic            wr_n,
  output logic            rd_n,
  output logic [2:0]      register_select,
  output logic            color_width_8,
  output logic [7:0]      host_data_bus_out,
  output logic            host_data_bus_oe_n,
  input  wire logic [7:0] host_data_bus_in
);

  typedef enum logic [1:0] {IDLE, SETUP, STROBE, HOLD} state_t;

  logic       rst_meta_n;
  logic       rst_sync_n;
  logic [7:0] data_meta;
  logic [7:0] data_sync;
  state_t     state;
  state_t     next_state;
  logic       is_write;
  logic       take;
  logic       strobe_end;
  logic       access_end;
  logic [7:0] next_pointer;
  logic [1:0] next_phase;
  logic [7:0] rd_fmt;

  phase_timer_if tim ();

  // Reset release through two flops
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Returning data pins pass two flops before use
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      data_meta <= 8'h00;
      data_sync <= 8'h00;
    end
    else
    begin
      data_meta <= host_data_bus_in;
      data_sync <= data_meta;
    end
  end

  phase_timer u_timer (
    .clk        (mclk),
    .rst_sync_n (rst_sync_n),
    .tim        (tim)
  );

  // Sequencer decode; no pixel clock is involved anywhere
  assign take       = (state == IDLE) && cmd_valid && cmd_ready;
  assign strobe_end = (state == STROBE) && tim.done;
  assign access_end = (state == HOLD) && tim.done;
  assign tim.load   = (next_state != state) && (next_state != IDLE);
  // Read strobe covers device access plus synchroniser delay
  assign tim.count  = (next_state == SETUP) ? SETUP_CYC :
                      (next_state == HOLD) ? HOLD_CYC :
                      is_write ? PULSE_CYC : RD_PULSE_CYC;
  // Narrow colour reads keep only the low six bits
  assign rd_fmt = fmt_color(data_sync, register_select, color_width_8);

  always_comb
  begin
    next_state = state;
    unique case (state)
      IDLE:   if (take) next_state = SETUP;
      SETUP:  if (tim.done) next_state = STROBE;
      STROBE: if (tim.done) next_state = HOLD;
      HOLD:   if (tim.done) next_state = IDLE;
    endcase
  end

  // Shadow of the device address register and colour phase
  always_comb
  begin
    next_pointer = entry_pointer;
    next_phase   = color_phase_count;
    if (is_addr_code(register_select))
    begin
      // Reads use the byte caught at strobe end; the pins are stale by now
      next_pointer = is_write ? host_data_bus_out : rsp_rdata;
      if (is_write)
        next_phase = PHASE_RED;
    end
    else if (is_color_code(register_select))
    begin
      if (color_phase_count == PHASE_BLUE)
      begin
        next_phase   = PHASE_RED;
        next_pointer = entry_pointer + PTR_STEP;
      end
      else
        next_phase = color_phase_count + PHASE_STEP;
    end
  end

  // Sequencer state
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      state <= IDLE;
    else
      state <= next_state;
  end

  // Command capture: select and data held for the whole access
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      is_write          <= 1'b0;
      register_select   <= SEL_ADDR_WR;
      host_data_bus_out <= 8'h00;
      color_width_8     <= 1'b1;
    end
    else if (take)
    begin
      is_write          <= cmd_write;
      register_select   <= cmd_select;
      color_width_8     <= wide_color;
      // Wide colour passes all eight bits, narrow drops six, seven
      host_data_bus_out <= fmt_color(cmd_wdata, cmd_select,
                                     wide_color);
    end
  end

  // Pin drive: strobes low only in STROBE, data driven only on writes
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      wr_n               <= 1'b1;
      rd_n               <= 1'b1;
      host_data_bus_oe_n <= 1'b1;
    end
    else
    begin
      wr_n <= !((next_state == STROBE) && is_write);
      rd_n <= !((next_state == STROBE) && !is_write);
      // Bus released on reads so only the device drives it
      // At take the stored access kind is stale, so use the command's
      host_data_bus_oe_n <= take ? !cmd_write
                                 : !((next_state != IDLE) && is_write);
    end
  end

  // Handshake, read data caught at strobe end, shadow update at access end
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      cmd_ready         <= 1'b0;
      rsp_valid         <= 1'b0;
      rsp_rdata         <= 8'h00;
      color_phase_count <= PHASE_RED;
      entry_pointer     <= 8'h00;
    end
    else
    begin
      cmd_ready <= (next_state == IDLE) && !take;
      rsp_valid <= access_end;
      if (strobe_end && !is_write)
        rsp_rdata <= rd_fmt;
      if (access_end)
      begin
        color_phase_count <= next_phase;
        entry_pointer     <= next_pointer;
      end
    end
  end

  // Helper: length of each read strobe
  logic [7:0] rd_low_cnt;
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      rd_low_cnt <= 8'h00;
    else if (rd_n)
      rd_low_cnt <= 8'h00;
    else
      rd_low_cnt <= rd_low_cnt + PTR_STEP;
  end

  chk_wr_data_held: assert property (@(posedge mclk)
    disable iff (!rst_sync_n)
    $rose(wr_n) |-> !host_data_bus_oe_n && $stable(host_data_bus_out)
                    ##1 !host_data_bus_oe_n[*2])
    else $error("write data not held across strobe rise");

  chk_wr_select_stable: assert property (@(posedge mclk)
    disable iff (!rst_sync_n)
    !wr_n |-> $stable(register_select) &&
              register_select == $past(register_select, 3))
    else $error("select moved around write strobe");

  chk_rd_low_len: assert property (@(posedge mclk)
    disable iff (!rst_sync_n)
    $rose(rd_n) |-> rd_low_cnt == RD_PULSE_CYC)
    else $error("read strobe length wrong");

  chk_rd_select_stable: assert property (@(posedge mclk)
    disable iff (!rst_sync_n)
    !rd_n |-> $stable(register_select) && host_data_bus_oe_n)
    else $error("select moved or bus driven during read");

  chk_phase_legal: assert property (@(posedge mclk)
    disable iff (!rst_sync_n)
    rsp_valid && is_write && is_addr_code(register_select)
      |-> color_phase_count == PHASE_RED && entry_pointer ==
          host_data_bus_out)
    else $error("address write did not reset colour phase");

  chk_narrow_write: assert property (@(posedge mclk)
    disable iff (!rst_sync_n)
    !wr_n && !color_width_8 && is_color_code(register_select)
      |-> host_data_bus_out[7:6] == 2'h0)
    else $error("narrow colour write drives upper bits");

endmodule

// file: rtl/palette_host_pkg.sv
// Constants, select codes and helpers for the palette host bus controller
package palette_host_pkg;

  // Clock rate
  localparam int CLK_PERIOD_NS = 4;

  // Pin timing, in nanoseconds
  localparam int T_SETUP_NS = 10;  // Select/data valid before strobe edge
  localparam int T_PULSE_NS = 50;  // Strobe low time
  localparam int T_HOLD_NS  = 10;  // Hold and recovery after strobe rises

  // Synchroniser depth on the returning data pins
  localparam int SYNC_STAGES = 2;

  // Cycle counts, least times rounded up
  localparam logic [7:0] SETUP_CYC =
    8'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] PULSE_CYC =
    8'((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] HOLD_CYC =
    8'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RD_PULSE_CYC = 8'(PULSE_CYC + 8'(SYNC_STAGES));

  // Register select codes
  localparam logic [2:0] SEL_ADDR_WR     = 3'h0;
  localparam logic [2:0] SEL_PALETTE     = 3'h1;
  localparam logic [2:0] SEL_READ_MASK   = 3'h2;
  localparam logic [2:0] SEL_ADDR_RD     = 3'h3;
  localparam logic [2:0] SEL_OVL_ADDR_WR = 3'h4;
  localparam logic [2:0] SEL_OVERLAY     = 3'h5;
  localparam logic [2:0] SEL_RESERVED    = 3'h6;
  localparam logic [2:0] SEL_OVL_ADDR_RD = 3'h7;

  // Colour phase values, narrow colour mask, pointer step and timer ends
  localparam logic [1:0] PHASE_RED   = 2'h0;
  localparam logic [1:0] PHASE_BLUE  = 2'h2;
  localparam logic [1:0] PHASE_STEP  = 2'h1;
  localparam logic [7:0] PTR_STEP    = 8'h01;
  localparam logic [7:0] COLOR6_MASK = 8'h3f;
  localparam logic [7:0] TIMER_LAST  = 8'h01;
  localparam logic [7:0] TIMER_ZERO  = 8'h00;

  // Select code addresses the address register
  function automatic logic is_addr_code(input logic [2:0] sel);
    is_addr_code = (sel == SEL_ADDR_WR) || (sel == SEL_ADDR_RD) ||
                   (sel == SEL_OVL_ADDR_WR) || (sel == SEL_OVL_ADDR_RD);
  endfunction

  // Select code addresses colour storage
  function automatic logic is_color_code(input logic [2:0] sel);
    is_color_code = (sel == SEL_PALETTE) || (sel == SEL_OVERLAY);
  endfunction

  // Narrow colour bytes keep only the low six bits
  function automatic logic [7:0] fmt_color(input logic [7:0] d,
                                           input logic [2:0] sel,
                                           input logic       wide);
    fmt_color = (is_color_code(sel) && !wide) ? (d & COLOR6_MASK) : d;
  endfunction

endpackage

// file: rtl/phase_timer_if.sv
// Load/expire handshake between the access sequencer and its timer
`timescale 1ns/100ps
interface phase_timer_if;
  logic       load;
  logic [7:0] count;
  logic       done;

  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

// file: rtl/phase_timer.sv
// Down counter that times each phase of a bus access
`timescale 1ns/100ps
module phase_timer
  import palette_host_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_sync_n,
  phase_timer_if.tmr tim
);

  logic [7:0] cnt;

  // Done in the last cycle of a phase loaded with count cycles; the load
  // request is left out so the sequencer's next state never loops back here
  assign tim.done = (cnt == TIMER_LAST);

  // Reload on request, otherwise count down to zero
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      cnt <= TIMER_ZERO;
    else if (tim.load)
      cnt <= tim.count;
    else if (cnt != TIMER_ZERO)
      cnt <= cnt - PTR_STEP;
  end

endmodule

// file: verif/palette_device_model.sv
// Behavioural palette device on the far side of the host port
`timescale 1ns/100ps
module palette_device_model
  import palette_host_pkg::*;
(
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  input  wire logic [2:0] sel,
  input  wire logic       width8,
  input  wire logic [7:0] host_out,
  input  wire logic       host_oe_n,
  output logic [7:0]      bus
);
  logic [7:0] ram [0:767];
  logic [7:0] ovl [0:47];
  logic [7:0] ptr   = 8'h00;
  logic [1:0] ph    = 2'h0;
  logic [7:0] mask  = 8'hff;
  logic [2:0] sel_q = 3'h0;
  logic [7:0] wd;
  logic [7:0] rd_val;
  int         idx;

  // Storage slot of the current entry and colour phase
  assign idx = (sel_q == SEL_OVERLAY) ? int'(ptr[3:0]) * 3 + int'(ph)
                                      : int'(ptr) * 3 + int'(ph);
  // Narrow colour writes drop the top two bits
  assign wd = width8 ? bus : {2'h0, bus[5:0]};

  // Selects latch on the falling edge of either strobe
  always @(negedge wr_n or negedge rd_n) sel_q = sel;

  // Phase steps R, G, B; pointer moves after blue and wraps
  task automatic step();
    if (ph == PHASE_BLUE)
    begin
      ph = PHASE_RED;
      ptr = ptr + 8'h01;
    end
    else ph = ph + 2'h1;
  endtask

  // Write completes on strobe rise with the latched select
  always @(posedge wr_n)
    case (sel_q)
      SEL_ADDR_WR, SEL_ADDR_RD, SEL_OVL_ADDR_WR, SEL_OVL_ADDR_RD:
      begin
        ptr = bus;
        ph = PHASE_RED;
      end
      SEL_READ_MASK: mask = bus;
      SEL_PALETTE: begin ram[idx] = wd; step(); end
      SEL_OVERLAY: begin ovl[idx] = wd; step(); end
      default: ;
    endcase

  // Colour reads advance the phase when the strobe ends
  always @(posedge rd_n)
    if (sel_q == SEL_PALETTE || sel_q == SEL_OVERLAY) step();

  // Read value; narrow colour reads give zero top bits
  always_comb
    case (sel_q)
      SEL_ADDR_WR, SEL_ADDR_RD, SEL_OVL_ADDR_WR, SEL_OVL_ADDR_RD: rd_val = ptr;
      SEL_READ_MASK: rd_val = mask;
      SEL_PALETTE: rd_val = width8 ? ram[idx] : {2'h0, ram[idx][5:0]};
      SEL_OVERLAY: rd_val = width8 ? ovl[idx] : {2'h0, ovl[idx][5:0]};
      default: rd_val = ~host_out;
    endcase

  // Device drives only while read is low; idle bus shows no stale value
  always @*
    if (!host_oe_n) bus = host_out;
    else if (!rd_n) bus = rd_val;
    else bus = ~host_out;
endmodule

// file: verif/palette_host_bus_port_test.sv
// Self-checking bench for the palette host bus controller
`timescale 1ns/100ps
module palette_host_bus_port_test;
  import palette_host_pkg::*;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cmd_valid = 1'b0;
  logic       cmd_write = 1'b0;
  logic [2:0] cmd_select = 3'h0;
  logic [7:0] cmd_wdata = 8'h00;
  logic       wide_color = 1'b1;
  logic       cmd_ready, rsp_valid, wr_n, rd_n, color_width_8, oe_n;
  logic [7:0] rsp_rdata, entry_pointer, bus_out, bus;
  logic [1:0] color_phase_count;
  logic [2:0] register_select;
  logic [7:0] rd;
  int         fail_count = 0;
  int         n_tests = 0;
  int         clash = 0;
  int         lat, wlat;

  always #2 mclk = ~mclk;

  palette_host_bus_port DUT (.mclk(mclk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_select(cmd_select), .cmd_wdata(cmd_wdata), .wide_color(wide_color),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .color_phase_count(color_phase_count), .entry_pointer(entry_pointer),
    .wr_n(wr_n), .rd_n(rd_n), .register_select(register_select),
    .color_width_8(color_width_8), .host_data_bus_out(bus_out),
    .host_data_bus_oe_n(oe_n), .host_data_bus_in(bus));

  palette_device_model device (.wr_n(wr_n), .rd_n(rd_n),
    .sel(register_select), .width8(color_width_8), .host_out(bus_out),
    .host_oe_n(oe_n), .bus(bus));

  // Host and device must never drive the bus together
  always @(negedge mclk) if (!rd_n && !oe_n) clash++;

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One access through the command port; rd holds the answer byte
  task automatic access(input logic wr, input logic [2:0] sel,
                        input logic [7:0] d, input logic wide);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_select <= sel;
    cmd_wdata <= d;
    wide_color <= wide;
    for (lat = 0; lat < 50; lat++)
    begin
      @(negedge mclk);
      if (cmd_ready) break;
    end
    if (!cmd_ready)
    begin
      fail_count++;
      $display("MISMATCH command take expected ready seen timeout");
      test_done();
    end
    @(posedge mclk);
    cmd_valid <= 1'b0;
    for (lat = 1; lat < 60; lat++)
    begin
      @(negedge mclk);
      if (rsp_valid) break;
    end
    if (lat >= 60)
    begin
      fail_count++;
      $display("MISMATCH answer wait expected done seen timeout");
      test_done();
    end
    rd = rsp_rdata;
  endtask

  task automatic t_reset();
    @(negedge mclk);
    check("idle pins", 8'h0f, {4'h0, wr_n, rd_n, oe_n, color_width_8});
    check("pointer", 8'h00, entry_pointer);
    check("ready idle", 8'h02, {6'h0, cmd_ready, rsp_valid});
    $display("Test reset done");
  endtask

  // Reset in mid-run clears the shadow and the port works again after it
  task automatic t_midreset();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check("pointer in reset", 8'h00, entry_pointer);
    check("pins in reset", 8'h07, {5'h0, wr_n, rd_n, oe_n});
    check("ready in reset", 8'h00, {7'h0, cmd_ready});
    @(posedge mclk);
    rst_n <= 1'b1;
    access(1'b1, SEL_ADDR_WR, 8'h20, 1'b1);
    access(1'b0, SEL_ADDR_RD, 8'h00, 1'b1);
    check("address after reset", 8'h20, rd);
    check("pointer after reset", 8'h20, entry_pointer);
    $display("Test midreset done");
  endtask

  task automatic t_wrap();
    access(1'b1, SEL_ADDR_WR, 8'hff, 1'b1);
    access(1'b1, SEL_PALETTE, 8'ha5, 1'b1);
    access(1'b1, SEL_PALETTE, 8'h5a, 1'b1);
    check("phase", 8'h02, {6'h0, color_phase_count});
    access(1'b1, SEL_PALETTE, 8'hc3, 1'b1);
    wlat = lat;
    check("wrapped pointer", 8'h00, entry_pointer);
    access(1'b1, SEL_ADDR_RD, 8'hff, 1'b1);
    access(1'b0, SEL_PALETTE, 8'h00, 1'b1);
    check("red", 8'ha5, rd);
    access(1'b0, SEL_ADDR_RD, 8'h00, 1'b1);
    check("address read", 8'hff, rd);
    check("kept phase", 8'h01, {6'h0, color_phase_count});
    access(1'b0, SEL_PALETTE, 8'h00, 1'b1);
    check("green", 8'h5a, rd);
    access(1'b0, SEL_PALETTE, 8'h00, 1'b1);
    check("blue", 8'hc3, rd);
    check("read pulse extra", RD_PULSE_CYC - PULSE_CYC, 8'(lat - wlat));
    check("pointer after reads", 8'h00, entry_pointer);
    $display("Test wrap done");
  endtask

  task automatic t_narrow();
    access(1'b1, SEL_ADDR_WR, 8'h10, 1'b0);
    access(1'b1, SEL_PALETTE, 8'hff, 1'b0);
    access(1'b1, SEL_PALETTE, 8'hc0, 1'b0);
    access(1'b1, SEL_PALETTE, 8'h7f, 1'b0);
    check("width pin", 8'h00, {7'h0, color_width_8});
    access(1'b1, SEL_ADDR_RD, 8'h10, 1'b0);
    check("full address byte", 8'h10, entry_pointer);
    access(1'b0, SEL_PALETTE, 8'h00, 1'b0);
    check("narrow red", 8'h3f, rd);
    access(1'b0, SEL_PALETTE, 8'h00, 1'b0);
    check("narrow green", 8'h00, rd);
    access(1'b0, SEL_PALETTE, 8'h00, 1'b0);
    check("narrow blue", 8'h3f, rd);
    $display("Test narrow done");
  endtask

  task automatic t_codes();
    access(1'b1, SEL_READ_MASK, 8'h96, 1'b1);
    access(1'b0, SEL_READ_MASK, 8'h00, 1'b1);
    check("mask", 8'h96, rd);
    access(1'b1, SEL_OVL_ADDR_WR, 8'h03, 1'b1);
    access(1'b1, SEL_OVERLAY, 8'h11, 1'b1);
    access(1'b1, SEL_OVERLAY, 8'h22, 1'b1);
    access(1'b1, SEL_OVERLAY, 8'h33, 1'b1);
    access(1'b1, SEL_OVL_ADDR_RD, 8'h03, 1'b1);
    access(1'b0, SEL_OVERLAY, 8'h00, 1'b1);
    check("overlay red", 8'h11, rd);
    access(1'b0, SEL_OVERLAY, 8'h00, 1'b1);
    access(1'b0, SEL_OVERLAY, 8'h00, 1'b1);
    check("overlay blue", 8'h33, rd);
    access(1'b0, SEL_OVL_ADDR_RD, 8'h00, 1'b1);
    check("overlay pointer", 8'h04, rd);
    access(1'b1, SEL_RESERVED, 8'h55, 1'b1);
    access(1'b0, SEL_ADDR_WR, 8'h00, 1'b1);
    check("reserved no effect", 8'h04, rd);
    check("bus fights", 8'h00, 8'(clash));
    $display("Test codes done");
  endtask

  initial
  begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_reset();
    t_wrap();
    t_narrow();
    t_codes();
    t_midreset();
    test_done();
  end
endmodule
